/* src/bsi_pkg.sv */
// shared types and constants for the boundary scan instruction decoder
package bsi_pkg;

    localparam int IR_W = 3;

    // instruction codes held in the test instruction register
    typedef enum logic [2:0] {
        INS_EXTEST   = 3'h0,
        INS_HIGHZ    = 3'h1,
        INS_SAMPLE   = 3'h2,
        INS_DRV_A    = 3'h3,
        INS_SHUTDOWN = 3'h4,
        INS_PRIVATE  = 3'h5,
        INS_DRV_B    = 3'h6,
        INS_BYPASS   = 3'h7
    } bsi_instr_t;

    localparam bsi_instr_t IR_RESET_VAL = INS_BYPASS;
    localparam logic [2:0] IR_CAPTURE_VAL = 3'h1;

    // test access port controller states, one-hot
    typedef enum logic [15:0] {
        TAP_RESET  = 16'h0001,
        TAP_IDLE   = 16'h0002,
        TAP_SEL_DR = 16'h0004,
        TAP_CAP_DR = 16'h0008,
        TAP_SH_DR  = 16'h0010,
        TAP_EX1_DR = 16'h0020,
        TAP_PA_DR  = 16'h0040,
        TAP_EX2_DR = 16'h0080,
        TAP_UP_DR  = 16'h0100,
        TAP_SEL_IR = 16'h0200,
        TAP_CAP_IR = 16'h0400,
        TAP_SH_IR  = 16'h0800,
        TAP_EX1_IR = 16'h1000,
        TAP_PA_IR  = 16'h2000,
        TAP_EX2_IR = 16'h4000,
        TAP_UP_IR  = 16'h8000
    } bsi_tap_t;

    // what the loaded instruction does to the device
    typedef struct packed {
        logic bsr_sel;    // boundary scan register is the active data register
        logic pins_float; // all outputs floating
        logic pins_test;  // outputs driven from the boundary scan update stage
        logic core_hold;  // core held off by shutdown
    } bsi_mode_t;

    localparam int MODE_W = 4;
    localparam bsi_mode_t MODE_RESET_VAL = 4'h0;

    // modes chosen by the strap levels at reset release
    typedef struct packed {
        logic mux_bus;       // address and data share bus timing
        logic data_latch_strobe;           // data latch strobe mode
        logic [2:0] drv_imp; // output driver impedance select
    } bsi_strap_t;

    localparam int STRAP_W = 5;
    localparam bsi_strap_t STRAP_RESET_VAL = 5'h00;

    localparam int CLK_PERIOD_NS = 8;
    localparam int STRAP_SETUP_NS = 20;
    localparam int STRAP_SETUP_CYC = (STRAP_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int BSR_LEN_DEF = 8;

endpackage

/* src/bsi_sync.sv */
// two flip-flop level synchroniser, one chain per bit
`timescale 1ns/100ps
module bsi_sync #(
    parameter int W = 1
) (
    input wire logic clk,          // destination clock
    input wire logic rst_n,        // synchronous reset, active low
    input wire logic [W-1:0] d,    // level from the other domain or a pin
    output logic [W-1:0] q         // synchronised level
);
    initial begin
        if (W < 1) begin
            $error("bsi_sync: width must be at least one");
        end
    end

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_r;
            logic sync_r;
            // the first stage feeds only the second
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                end else begin
                    meta_r <= d[i];
                    sync_r <= meta_r;
                end
            end
            assign q[i] = sync_r;
        end
    endgenerate
endmodule

/* src/bsi_strap.sv */
// captures the mode strap levels when system reset is released
`timescale 1ns/100ps
module bsi_strap (
    input wire logic clk,                  // system clock
    input wire logic rst_n,                // synchronous reset, active low
    input wire logic sys_rst_asserted,     // synchronised system reset, high while asserted
    input wire bsi_pkg::bsi_strap_t level, // synchronised strap levels, already in asserted sense
    output bsi_pkg::bsi_strap_t mode,      // modes latched at release
    output logic setup_ok                  // straps were steady long enough before release
);
    logic rst_prev_r;
    logic [2:0] stable_cnt_r;
    bsi_pkg::bsi_strap_t level_prev_r;
    logic release_evt;

    assign release_evt = rst_prev_r & ~sys_rst_asserted;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rst_prev_r <= 1'b0;
            level_prev_r <= bsi_pkg::STRAP_RESET_VAL;
        end else begin
            rst_prev_r <= sys_rst_asserted;
            level_prev_r <= level;
        end
    end

    // counts how long the straps have held still, saturating at the setup figure
    always_ff @(posedge clk) begin
        if (!rst_n || level != level_prev_r) begin
            stable_cnt_r <= 3'h0;
        end else if (stable_cnt_r < 3'(bsi_pkg::STRAP_SETUP_CYC)) begin
            stable_cnt_r <= stable_cnt_r + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode <= bsi_pkg::STRAP_RESET_VAL;
            setup_ok <= 1'b0;
        end else if (release_evt) begin
            mode <= level; // R9 R10 R11
            setup_ok <= (stable_cnt_r >= 3'(bsi_pkg::STRAP_SETUP_CYC)) && (level == level_prev_r); // R11
        end
    end
endmodule

/* src/bsi_tap.sv */
// test access port with 3-bit instruction decode and reset strap sampling
//
// Operation
// R1: 3-bit IR; 000 extest, boundary scan
// R2: 001 high-impedance, outputs float, bypass register
// R3: 010 sample/preload, boundary scan between TDI/TDO
// R4: 011 first driver-control test, boundary scan
// R5: 100 shutdown, bypass register selected
// R6: 101 private instruction, bypass register selected
// R7: 110 second driver-control test, boundary scan
// R8: 111 bypass, single-bit bypass register only
// R9: cache-disable strap at reset release: multiplexed bus
// R10: translation strap: latch mode; priority inputs: impedance
// R11: straps sampled at release, 20 ns setup
// R12: resets, handshakes, grant, priority inputs active low
// R13: IR loads at update-IR; test reset loads bypass
`timescale 1ns/100ps
module bsi_tap #(
    parameter int BSR_LEN = bsi_pkg::BSR_LEN_DEF
) (
    input wire logic clk,                              // system clock, 125 MHz
    input wire logic rst_n,                            // synchronous reset of the system side, active low
    input wire logic tck,                              // test clock from the external controller
    input wire logic trst_n,                           // test reset, active low, sampled on tck
    input wire logic tms,                              // test mode select, sampled on rising tck
    input wire logic tdi,                              // test data in, sampled on rising tck
    output logic tdo,                                  // test data out, changes on falling tck
    output logic tdo_oe,                               // high while tdo is driven
    input wire logic [BSR_LEN-1:0] bsr_pin_in,         // pin levels seen by the capture cells
    output logic [BSR_LEN-1:0] bsr_pin_out,            // levels the update cells present to the pins
    output logic pin_test_drive,                       // tck side: pins take bsr_pin_out
    output bsi_pkg::bsi_instr_t instr,                 // instruction currently in force
    input wire logic system_reset_in_n,                // system reset pin, active low
    input wire logic cache_disable_strap_n,            // strap, active low
    input wire logic translation_disable_strap_n,      // strap, active low
    input wire logic [2:0] interrupt_priority_inputs_n, // priority pins, active low, straps at reset
    output logic pins_float,                           // clk side: all outputs floating
    output logic pins_test,                            // clk side: outputs follow boundary scan
    output logic core_hold,                            // clk side: core held by shutdown
    output bsi_pkg::bsi_strap_t strap_mode,            // modes latched at system reset release
    output logic strap_setup_ok,                       // straps held steady before release
    output logic system_reset_out_n                    // system reset as seen by the core, active low
);
    initial begin
        if (BSR_LEN < 1) begin
            $error("bsi_tap: boundary scan register needs at least one cell");
        end
    end

    // ---------------- tck domain ----------------

    bsi_pkg::bsi_tap_t tap_r;
    bsi_pkg::bsi_tap_t tap_nxt;
    logic [bsi_pkg::IR_W-1:0] ir_sh_r;
    bsi_pkg::bsi_instr_t ir_r;
    bsi_pkg::bsi_mode_t mode_r;
    logic byp_r;
    logic [BSR_LEN-1:0] bsr_sh_r;
    logic [BSR_LEN-1:0] bsr_upd_r;
    logic [BSR_LEN-1:0] bsr_pin_s;
    logic tdo_r;
    logic tdo_oe_r;

    // what each instruction code does; every code is defined
    function automatic bsi_pkg::bsi_mode_t decode(input logic [bsi_pkg::IR_W-1:0] code);
        bsi_pkg::bsi_mode_t m;
        m = bsi_pkg::MODE_RESET_VAL;
        unique case (code)
            bsi_pkg::INS_EXTEST: begin
                m.bsr_sel = 1'b1; // R1
                m.pins_test = 1'b1; // R1
            end
            bsi_pkg::INS_HIGHZ: begin
                m.pins_float = 1'b1; // R2
            end
            bsi_pkg::INS_SAMPLE: begin
                m.bsr_sel = 1'b1; // R3
            end
            bsi_pkg::INS_DRV_A: begin
                m.bsr_sel = 1'b1; // R4
                m.pins_test = 1'b1; // R4
            end
            bsi_pkg::INS_SHUTDOWN: begin
                m.pins_float = 1'b1; // R5
                m.core_hold = 1'b1; // R5
            end
            bsi_pkg::INS_PRIVATE: begin
                m.bsr_sel = 1'b0; // R6
            end
            bsi_pkg::INS_DRV_B: begin
                m.bsr_sel = 1'b1; // R7
                m.pins_test = 1'b1; // R7
            end
            bsi_pkg::INS_BYPASS: begin
                m.bsr_sel = 1'b0; // R8
            end
        endcase
        return m;
    endfunction

    always_comb begin
        tap_nxt = tap_r;
        unique case (tap_r)
            bsi_pkg::TAP_RESET: begin
                tap_nxt = tms ? bsi_pkg::TAP_RESET : bsi_pkg::TAP_IDLE;
            end
            bsi_pkg::TAP_IDLE: begin
                tap_nxt = tms ? bsi_pkg::TAP_SEL_DR : bsi_pkg::TAP_IDLE;
            end
            bsi_pkg::TAP_SEL_DR: begin
                tap_nxt = tms ? bsi_pkg::TAP_SEL_IR : bsi_pkg::TAP_CAP_DR;
            end
            bsi_pkg::TAP_CAP_DR: begin
                tap_nxt = tms ? bsi_pkg::TAP_EX1_DR : bsi_pkg::TAP_SH_DR;
            end
            bsi_pkg::TAP_SH_DR: begin
                tap_nxt = tms ? bsi_pkg::TAP_EX1_DR : bsi_pkg::TAP_SH_DR;
            end
            bsi_pkg::TAP_EX1_DR: begin
                tap_nxt = tms ? bsi_pkg::TAP_UP_DR : bsi_pkg::TAP_PA_DR;
            end
            bsi_pkg::TAP_PA_DR: begin
                tap_nxt = tms ? bsi_pkg::TAP_EX2_DR : bsi_pkg::TAP_PA_DR;
            end
            bsi_pkg::TAP_EX2_DR: begin
                tap_nxt = tms ? bsi_pkg::TAP_UP_DR : bsi_pkg::TAP_SH_DR;
            end
            bsi_pkg::TAP_UP_DR: begin
                tap_nxt = tms ? bsi_pkg::TAP_SEL_DR : bsi_pkg::TAP_IDLE;
            end
            bsi_pkg::TAP_SEL_IR: begin
                tap_nxt = tms ? bsi_pkg::TAP_RESET : bsi_pkg::TAP_CAP_IR;
            end
            bsi_pkg::TAP_CAP_IR: begin
                tap_nxt = tms ? bsi_pkg::TAP_EX1_IR : bsi_pkg::TAP_SH_IR;
            end
            bsi_pkg::TAP_SH_IR: begin
                tap_nxt = tms ? bsi_pkg::TAP_EX1_IR : bsi_pkg::TAP_SH_IR;
            end
            bsi_pkg::TAP_EX1_IR: begin
                tap_nxt = tms ? bsi_pkg::TAP_UP_IR : bsi_pkg::TAP_PA_IR;
            end
            bsi_pkg::TAP_PA_IR: begin
                tap_nxt = tms ? bsi_pkg::TAP_EX2_IR : bsi_pkg::TAP_PA_IR;
            end
            bsi_pkg::TAP_EX2_IR: begin
                tap_nxt = tms ? bsi_pkg::TAP_UP_IR : bsi_pkg::TAP_SH_IR;
            end
            bsi_pkg::TAP_UP_IR: begin
                tap_nxt = tms ? bsi_pkg::TAP_SEL_DR : bsi_pkg::TAP_IDLE;
            end
            default: begin
                tap_nxt = bsi_pkg::TAP_RESET;
            end
        endcase
    end

    always_ff @(posedge tck) begin
        if (!trst_n) begin // R12
            tap_r <= bsi_pkg::TAP_RESET;
        end else begin
            tap_r <= tap_nxt;
        end
    end

    // instruction shift stage; captures the fixed pattern, shifts lsb first
    always_ff @(posedge tck) begin
        if (!trst_n) begin
            ir_sh_r <= bsi_pkg::IR_CAPTURE_VAL;
        end else if (tap_r == bsi_pkg::TAP_CAP_IR) begin
            ir_sh_r <= bsi_pkg::IR_CAPTURE_VAL;
        end else if (tap_r == bsi_pkg::TAP_SH_IR) begin
            ir_sh_r <= {tdi, ir_sh_r[bsi_pkg::IR_W-1:1]}; // R1
        end
    end

    // the instruction in force changes only on update or test reset, so shifting never glitches the pins
    always_ff @(posedge tck) begin
        if (!trst_n || tap_r == bsi_pkg::TAP_RESET) begin
            ir_r <= bsi_pkg::IR_RESET_VAL; // R13
            mode_r <= decode(bsi_pkg::IR_RESET_VAL); // R13
        end else if (tap_r == bsi_pkg::TAP_UP_IR) begin
            ir_r <= bsi_pkg::bsi_instr_t'(ir_sh_r); // R13
            mode_r <= decode(ir_sh_r); // R13
        end
    end

    // single-bit bypass register, captures zero
    always_ff @(posedge tck) begin
        if (!trst_n) begin
            byp_r <= 1'b0;
        end else if (!mode_r.bsr_sel && tap_r == bsi_pkg::TAP_CAP_DR) begin
            byp_r <= 1'b0; // R2 R5 R6 R8
        end else if (!mode_r.bsr_sel && tap_r == bsi_pkg::TAP_SH_DR) begin
            byp_r <= tdi; // R2 R5 R6 R8
        end
    end

    // pin levels are asynchronous to tck, so capture reads them through a synchroniser
    bsi_sync #(
        .W(BSR_LEN)
    ) u_pin_sync (
        .clk(tck),
        .rst_n(trst_n),
        .d(bsr_pin_in),
        .q(bsr_pin_s)
    );

    always_ff @(posedge tck) begin
        if (!trst_n) begin
            bsr_sh_r <= '0;
        end else if (mode_r.bsr_sel && tap_r == bsi_pkg::TAP_CAP_DR) begin
            bsr_sh_r <= bsr_pin_s; // R3
        end else if (mode_r.bsr_sel && tap_r == bsi_pkg::TAP_SH_DR) begin
            bsr_sh_r <= {tdi, bsr_sh_r[BSR_LEN-1:1]}; // R1 R3 R4 R7
        end
    end

    // update stage holds the preloaded pattern while shifting goes on
    always_ff @(posedge tck) begin
        if (!trst_n) begin
            bsr_upd_r <= '0;
        end else if (mode_r.bsr_sel && tap_r == bsi_pkg::TAP_UP_DR) begin
            bsr_upd_r <= bsr_sh_r; // R3
        end
    end

    // tdo moves on the falling edge so the controller samples a settled bit
    always_ff @(negedge tck) begin
        if (!trst_n) begin
            tdo_r <= 1'b0;
            tdo_oe_r <= 1'b0;
        end else begin
            tdo_oe_r <= (tap_r == bsi_pkg::TAP_SH_DR) || (tap_r == bsi_pkg::TAP_SH_IR);
            if (tap_r == bsi_pkg::TAP_SH_IR) begin
                tdo_r <= ir_sh_r[0];
            end else if (mode_r.bsr_sel) begin
                tdo_r <= bsr_sh_r[0]; // R1 R3 R4 R7
            end else begin
                tdo_r <= byp_r; // R2 R5 R6 R8
            end
        end
    end

    assign tdo = tdo_r;
    assign tdo_oe = tdo_oe_r;
    assign bsr_pin_out = bsr_upd_r;
    assign pin_test_drive = mode_r.pins_test;
    assign instr = ir_r;

    // ---------------- clk domain ----------------

    logic [2:0] mode_s;
    logic [5:0] pin_s;
    logic sys_rst_asserted;
    bsi_pkg::bsi_strap_t strap_level;

    // mode bits are steady levels between updates, so a plain per-bit synchroniser is enough
    bsi_sync #(
        .W(3)
    ) u_mode_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({mode_r.pins_float, mode_r.pins_test, mode_r.core_hold}),
        .q(mode_s)
    );

    assign pins_float = mode_s[2]; // R2 R5
    assign pins_test = mode_s[1];
    assign core_hold = mode_s[0]; // R5

    // reset and strap pins arrive from outside and pass two stages before use
    bsi_sync #(
        .W(6)
    ) u_pin_in_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({system_reset_in_n, cache_disable_strap_n, translation_disable_strap_n,
            interrupt_priority_inputs_n}),
        .q(pin_s)
    );

    // raw levels are synchronised, so a flushed chain reads as system reset held, never a false release
    assign sys_rst_asserted = ~pin_s[5]; // R12
    assign strap_level.mux_bus = ~pin_s[4]; // R9 R12
    assign strap_level.data_latch_strobe = ~pin_s[3]; // R10 R12
    assign strap_level.drv_imp = ~pin_s[2:0]; // R10 R12

    bsi_strap u_strap (
        .clk(clk),
        .rst_n(rst_n),
        .sys_rst_asserted(sys_rst_asserted),
        .level(strap_level),
        .mode(strap_mode),
        .setup_ok(strap_setup_ok)
    );

    // core reset follows the synchronised pin; held low during our own reset too
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            system_reset_out_n <= 1'b0;
        end else begin
            system_reset_out_n <= ~sys_rst_asserted; // R12
        end
    end
endmodule

/* bench/bsi_tap_assertions.sv */
// port-level assertions for the boundary scan decoder
`timescale 1ns/100ps
module bsi_tap_checker #(
    parameter int BSR_LEN = 8
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // system reset
    input wire logic tck, // test clock
    input wire logic trst_n, // test reset
    input wire logic tms, // mode select
    input wire logic tdo_oe, // tdo driven
    input wire logic pin_test_drive, // pins from bsr
    input wire bsi_pkg::bsi_instr_t instr, // instruction
    input wire logic system_reset_in_n, // reset pin
    input wire logic cache_disable_strap_n, // strap
    input wire logic translation_disable_strap_n, // strap
    input wire logic [2:0] interrupt_priority_inputs_n, // straps
    input wire logic pins_float, // floating
    input wire logic pins_test, // test drive
    input wire logic core_hold, // shutdown
    input wire bsi_pkg::bsi_strap_t strap_mode, // latched modes
    input wire logic system_reset_out_n // core reset
);
    // update-ir and test-logic-reset are both reached only after two tms highs
    property p_ir_update;
        @(posedge tck) disable iff (!trst_n)
        $changed(instr) && $past(trst_n) |-> $past(tms, 2) && $past(tms, 3);
    endproperty
    a_ir_update: assert property (p_ir_update) else $error("instruction changed off update");
    property p_drive_dec;
        @(posedge tck) disable iff (!trst_n)
        pin_test_drive == (instr inside {bsi_pkg::INS_EXTEST, bsi_pkg::INS_DRV_A, bsi_pkg::INS_DRV_B});
    endproperty
    a_drive_dec: assert property (p_drive_dec) else $error("pin drive decode wrong");
    property p_oe_enter;
        @(negedge tck) disable iff (!trst_n) $rose(tdo_oe) |-> !$past(tms);
    endproperty
    a_oe_enter: assert property (p_oe_enter) else $error("tdo enabled without shift entry");
    property p_oe_leave;
        @(negedge tck) disable iff (!trst_n) $fell(tdo_oe) |-> $past(tms);
    endproperty
    a_oe_leave: assert property (p_oe_leave) else $error("tdo released without shift exit");
    property p_core_float;
        @(posedge clk) disable iff (!rst_n) core_hold |-> pins_float && !pins_test;
    endproperty
    a_core_float: assert property (p_core_float) else $error("shutdown without floating pins");
    property p_float_excl;
        @(posedge clk) disable iff (!rst_n) pins_float |-> !pins_test;
    endproperty
    a_float_excl: assert property (p_float_excl) else $error("pins float and driven");
    property p_rst_path;
        @(posedge clk) disable iff (!rst_n) system_reset_out_n == $past(system_reset_in_n, 3);
    endproperty
    a_rst_path: assert property (p_rst_path) else $error("reset out latency wrong");
    property p_strap_latch;
        @(posedge clk) disable iff (!rst_n) $rose(system_reset_out_n) |-> ##[0:2]
        strap_mode == {~cache_disable_strap_n, ~translation_disable_strap_n, ~interrupt_priority_inputs_n};
    endproperty
    a_strap_latch: assert property (p_strap_latch) else $error("strap modes not latched");
    property p_strap_hold;
        @(posedge clk) disable iff (!rst_n)
        system_reset_out_n && $past(system_reset_out_n, 3) |-> $stable(strap_mode);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap modes moved after release");
endmodule

bind bsi_tap bsi_tap_checker #(.BSR_LEN(BSR_LEN)) u_chk (
    .clk(clk), .rst_n(rst_n), .tck(tck), .trst_n(trst_n), .tms(tms), .tdo_oe(tdo_oe),
    .pin_test_drive(pin_test_drive), .instr(instr), .system_reset_in_n(system_reset_in_n),
    .cache_disable_strap_n(cache_disable_strap_n), .translation_disable_strap_n(translation_disable_strap_n),
    .interrupt_priority_inputs_n(interrupt_priority_inputs_n), .pins_float(pins_float),
    .pins_test(pins_test), .core_hold(core_hold), .strap_mode(strap_mode),
    .system_reset_out_n(system_reset_out_n)
);

/* bench/bsi_jtag_ctl.sv */
// behavioural external test controller
`timescale 1ns/100ps
module bsi_jtag_ctl (
    output logic tck, // test clock, still between frames
    output logic trst_n, // test reset
    output logic tms, // mode select
    output logic tdi, // data to device
    input wire logic tdo, // data from device
    input wire logic tdo_oe // tdo driven
);
    int low_ns = 40;
    logic tdo_smp = 1'b0;
    initial begin
        tck = 1'b0;
        trst_n = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // levels change while tck is low and hold over the rising edge
    task automatic pulse(input logic m, input logic d);
        tms = m;
        tdi = d;
        #(low_ns);
        // tdo has no pull, so an undriven line reads as the inverse of the last bit
        tdo_smp = tdo_oe ? tdo : ~tdo_smp;
        tck = 1'b1;
        #40;
        tck = 1'b0;
    endtask
    // release 10 ns into the low phase, clear of the falling edge that also samples it
    task automatic rst_tap();
        trst_n = 1'b0;
        pulse(1'b1, 1'b0);
        pulse(1'b1, 1'b0);
        #10;
        trst_n = 1'b1;
        // leave test-logic-reset so the next scan starts from idle
        pulse(1'b0, 1'b0);
    endtask
endmodule

/* bench/tb_boundary_scan_instr_decode.sv */
// self-checking bench for the boundary scan instruction decoder
`timescale 1ns/100ps
module tb_boundary_scan_instr_decode;
    logic clk, rst_n, tck, trst_n, tms, tdi, tdo, tdo_oe;
    logic pin_test_drive, pins_float, pins_test, core_hold, strap_setup_ok, rst_in_n, rst_out_n;
    logic cds_n, tds_n;
    logic [2:0] ipl_n;
    logic [7:0] pin_in, pin_out;
    bsi_pkg::bsi_instr_t instr;
    bsi_pkg::bsi_strap_t strap_mode;
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;

    bsi_tap #(.BSR_LEN(8)) DUT (
        .clk(clk), .rst_n(rst_n), .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe), .bsr_pin_in(pin_in), .bsr_pin_out(pin_out), .pin_test_drive(pin_test_drive),
        .instr(instr), .system_reset_in_n(rst_in_n), .cache_disable_strap_n(cds_n),
        .translation_disable_strap_n(tds_n), .interrupt_priority_inputs_n(ipl_n),
        .pins_float(pins_float), .pins_test(pins_test), .core_hold(core_hold),
        .strap_mode(strap_mode), .strap_setup_ok(strap_setup_ok), .system_reset_out_n(rst_out_n)
    );
    bsi_jtag_ctl ctl (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic complete_run();
        if (fails == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // the run needs some 3100 cycles, so this only trips on a hang
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            $display("ERROR %0t timeout", $time);
            complete_run();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    function automatic logic bsr_sel(input logic [2:0] c);
        return c == 3'h0 || c == 3'h2 || c == 3'h3 || c == 3'h6;
    endfunction

    // {float, test, hold, drive}
    function automatic logic [7:0] exp_mode(input logic [2:0] c);
        logic drv;
        drv = c == 3'h0 || c == 3'h3 || c == 3'h6;
        return {4'h0, c == 3'h1 || c == 3'h4, drv, c == 3'h4, drv};
    endfunction

    task automatic walk(input logic [7:0] seq, input int n);
        for (int i = 0; i < n; i++) begin
            ctl.pulse(seq[i], 1'($urandom));
        end
    endtask

    task automatic load_ir(input logic [2:0] code);
        logic [2:0] cap;
        logic [2:0] old;
        #1.3;
        old = instr;
        walk(8'h03, 4);
        for (int i = 0; i < 3; i++) begin
            ctl.pulse(i == 2, code[i]);
            cap[i] = ctl.tdo_smp;
        end
        check({5'h00, cap}, 8'h01, "ir capture");
        check({5'h00, instr}, {5'h00, old}, "early ir");
        walk(8'h01, 2);
        check({5'h00, instr}, {5'h00, code}, "ir load");
    endtask

    task automatic scan_dr(input logic [7:0] din, output logic [7:0] dout);
        #1.3;
        walk(8'h01, 3);
        for (int i = 0; i < 8; i++) begin
            ctl.pulse(i == 7, din[i]);
            dout[i] = ctl.tdo_smp;
        end
        walk(8'h01, 2);
    endtask

    task automatic run_code(input logic [2:0] code);
        logic [7:0] din, dout;
        din = $urandom;
        load_ir(code);
        @(negedge clk);
        pin_in = $urandom;
        repeat (8) @(negedge clk);
        check({4'h0, pins_float, pins_test, core_hold, pin_test_drive}, exp_mode(code), "mode");
        scan_dr(din, dout);
        check(dout, bsr_sel(code) ? pin_in : {din[6:0], 1'b0}, "scan out");
        if (bsr_sel(code)) begin
            check(pin_out, din, "update");
        end
    endtask

    // late moves a strap one cycle before release, inside the setup window
    task automatic strap_case(input logic late);
        logic [4:0] s;
        s = $urandom;
        @(negedge clk);
        rst_in_n = 1'b0;
        {cds_n, tds_n, ipl_n} = ~s;
        repeat (6) @(negedge clk);
        if (late) begin
            s[0] = ~s[0];
            ipl_n[0] = ~s[0];
        end
        @(negedge clk);
        rst_in_n = 1'b1;
        repeat (8) @(negedge clk);
        check({3'h0, strap_mode}, {3'h0, s}, "strap mode");
        check({7'h00, strap_setup_ok}, {7'h00, ~late}, "strap setup");
    endtask

    initial begin
        void'($urandom(32'h22ba2f0d));
        rst_n = 1'b0;
        rst_in_n = 1'b0;
        {cds_n, tds_n, ipl_n} = 5'h1F;
        pin_in = 8'h00;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        strap_case(1'b0);
        ctl.rst_tap();
        check({5'h00, instr}, 8'h07, "trst load");
        for (int k = 0; k < 12; k++) begin
            run_code(k < 8 ? 3'(k) : 3'($urandom));
        end
        load_ir(3'h0);
        walk(8'h1F, 6);
        check({5'h00, instr}, 8'h07, "tap reset");
        load_ir(3'h2);
        ctl.rst_tap();
        check({5'h00, instr}, 8'h07, "trst mid run");
        strap_case(1'b1);
        complete_run();
    end
endmodule
